// ===== port_regs_defs.vh
// constants for the port direction, data latch and pull-up register block
`ifndef PORT_REGS_DEFS_VH
`define PORT_REGS_DEFS_VH

// register byte addresses
`define PORT0_DATA_ADDR 16'hFF00
`define PORT1_DATA_ADDR 16'hFF01
`define PORT2_LEVEL_ADDR 16'hFF02
`define PORT5_DATA_ADDR 16'hFF05
`define PORT0_DIR_ADDR 16'hFF20
`define PORT1_DIR_ADDR 16'hFF21
`define PORT5_DIR_ADDR 16'hFF25
`define PORT0_PULLUP_ADDR 16'hFF30
`define PORT1_PULLUP_ADDR 16'hFF31
`define PORT5_PULLUP_ADDR 16'hFF35

// implemented pin masks
`define PORT0_MASK 8'h0F
`define PORT1_MASK 8'hD8
`define PORT2_MASK 8'h0F
`define PORT5_MASK 8'h19

// reset values
`define DIR_RESET 8'hFF
`define LATCH_RESET 8'h00
`define PULLUP_RESET 8'h00
`define BYTE_ZERO 8'h00

// alternate-function bit positions
`define TXD_BIT 4
`define RXD_BIT 3
`define FLASH_MODE_BIT 7
`define TIMER_A_BIT 0
`define TIMER_B_FIRST_BIT 3
`define TIMER_B_SECOND_BIT 4
`define IRQ_FIVE_BIT 3
`define CONV_TRIG_BIT 3
`define OUT_STOP_BIT 0

// internal port slot numbers
`define SLOT_PORT0 0
`define SLOT_PORT1 1
`define SLOT_PORT5 2

`endif

// ===== port_regs.v
// port direction, data latch, pin read and pull-up control registers
`timescale 1ns/100ps
// Notes on behaviour
// - each direction bit controls its own pin
// - direction 0 drives pin, 1 is input
// - direction registers reset to all ones
// - unimplemented direction bits read as one
// - data write loads latch, latch drives outputs
// - read returns pin when input, latch otherwise
// - output latches reset to zero
// - port 2 read-only, unimplemented data bits zero
// - registers take bit and byte writes
// - pull-up bit one requests the pull-up
// - pull-up only when bit set and input
// - no pull-up on output or alternate output
// - pull-up registers reset to zero
// - latch write in input mode still stored
// - bit write is byte read-modify-write
`include "port_regs_defs.vh"

module port_regs (
  input wire clk,
  input wire nrst,
  input wire [15:0] busAddr,
  input wire busWrEn,
  input wire [7:0] busWrData,
  input wire busBitWrEn,
  input wire [2:0] busBitSel,
  input wire busBitVal,
  input wire busRdEn,
  output wire [7:0] busRdData,
  output wire busRdValid,
  input wire [7:0] port0PinIn,
  output wire [7:0] port0PinOut,
  output wire [7:0] port0PinOe,
  output wire [7:0] port0Pullup,
  input wire [7:0] port1PinIn,
  output wire [7:0] port1PinOut,
  output wire [7:0] port1PinOe,
  output wire [7:0] port1Pullup,
  input wire [7:0] port5PinIn,
  output wire [7:0] port5PinOut,
  output wire [7:0] port5PinOe,
  output wire [7:0] port5Pullup,
  input wire [3:0] port2PinIn,
  input wire serialTransmitOut,
  input wire timerAOutput,
  input wire timerBOutput,
  output wire serialReceiveIn,
  output wire flashModeSelect,
  output wire timerAInput,
  output wire timerBInputFirst,
  output wire timerBInputSecond,
  output wire [3:0] extIrqLines,
  output wire extIrqLineFive,
  output wire converterTriggerIn,
  output wire timerOutputStopIn
);

  // implemented-pin mask of a port slot
  function [7:0] portMask;
    input integer slot;
    begin
      case (slot)
        `SLOT_PORT0: portMask = `PORT0_MASK;
        `SLOT_PORT1: portMask = `PORT1_MASK;
        default: portMask = `PORT5_MASK;
      endcase
    end
  endfunction

  function [15:0] dataAddr;
    input integer slot;
    begin
      case (slot)
        `SLOT_PORT0: dataAddr = `PORT0_DATA_ADDR;
        `SLOT_PORT1: dataAddr = `PORT1_DATA_ADDR;
        default: dataAddr = `PORT5_DATA_ADDR;
      endcase
    end
  endfunction

  function [15:0] dirAddr;
    input integer slot;
    begin
      case (slot)
        `SLOT_PORT0: dirAddr = `PORT0_DIR_ADDR;
        `SLOT_PORT1: dirAddr = `PORT1_DIR_ADDR;
        default: dirAddr = `PORT5_DIR_ADDR;
      endcase
    end
  endfunction

  function [15:0] pullupAddr;
    input integer slot;
    begin
      case (slot)
        `SLOT_PORT0: pullupAddr = `PORT0_PULLUP_ADDR;
        `SLOT_PORT1: pullupAddr = `PORT1_PULLUP_ADDR;
        default: pullupAddr = `PORT5_PULLUP_ADDR;
      endcase
    end
  endfunction

  // replace one bit of a byte; used by every bit-write path
  function [7:0] setBit;
    input [7:0] cur;
    input [2:0] sel;
    input val;
    reg [7:0] oneHot;
    begin
      oneHot = 8'h01 << sel;
      setBit = val ? (cur | oneHot) : (cur & ~oneHot);
    end
  endfunction

  wire [7:0] pinRaw [0:2];
  wire [7:0] dataRd [0:2];
  wire [7:0] dirRd [0:2];
  wire [7:0] pullupRd [0:2];
  wire [7:0] pinLevel [0:2];
  wire [7:0] altOr [0:2];
  wire [7:0] altAnd [0:2];

  assign pinRaw[`SLOT_PORT0] = port0PinIn;
  assign pinRaw[`SLOT_PORT1] = port1PinIn;
  assign pinRaw[`SLOT_PORT5] = port5PinIn;

  // transmit idles high, so the latch (set to 1) gates it onto the pin;
  // timer outputs are ORed with a latch that software leaves at 0
  assign altAnd[`SLOT_PORT0] = 8'hFF;
  assign altAnd[`SLOT_PORT1] = ~(8'h01 << `TXD_BIT) | ({8{serialTransmitOut}} & (8'h01 << `TXD_BIT));
  assign altAnd[`SLOT_PORT5] = 8'hFF;
  assign altOr[`SLOT_PORT0] = `BYTE_ZERO;
  assign altOr[`SLOT_PORT1] = `BYTE_ZERO;
  assign altOr[`SLOT_PORT5] = ({8{timerAOutput}} & (8'h01 << `TIMER_A_BIT))
    | ({8{timerBOutput}} & (8'h01 << `TIMER_B_SECOND_BIT));

  reg [7:0] pinOutQ [0:2];
  reg [7:0] pinOeQ [0:2];
  reg [7:0] pullupOutQ [0:2];

  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_port
      reg [7:0] syncAQ;
      reg [7:0] syncBQ;
      reg [7:0] dirQ;
      reg [7:0] latchQ;
      reg [7:0] pullupQ;
      wire [7:0] mask;
      wire hitData;
      wire hitDir;
      wire hitPullup;

      assign mask = portMask(k);
      assign hitData = (busAddr == dataAddr(k));
      assign hitDir = (busAddr == dirAddr(k));
      assign hitPullup = (busAddr == pullupAddr(k));

      // two-stage pin synchroniser; only the second stage is read
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          syncAQ <= `BYTE_ZERO;
          syncBQ <= `BYTE_ZERO;
        end
        else
        begin
          syncAQ <= pinRaw[k];
          syncBQ <= syncAQ;
        end
      end
      assign pinLevel[k] = syncBQ;

      // per bit: input mode shows the pin, output mode the latch
      assign dataRd[k] = ((dirQ & syncBQ) | (~dirQ & latchQ)) & mask;
      assign dirRd[k] = dirQ | ~mask;
      assign pullupRd[k] = pullupQ & mask;

      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          dirQ <= `DIR_RESET;
          latchQ <= `LATCH_RESET;
          pullupQ <= `PULLUP_RESET;
        end
        else
        begin
          if (hitDir && busWrEn)
            dirQ <= busWrData | ~mask;
          else if (hitDir && busBitWrEn)
            dirQ <= setBit(dirRd[k], busBitSel, busBitVal) | ~mask;
          // latch is written in either mode; an input pin simply stays undriven
          if (hitData && busWrEn)
            latchQ <= busWrData & mask;
          else if (hitData && busBitWrEn)
            // whole byte read back, so input bits take their pin level
            latchQ <= setBit(dataRd[k], busBitSel, busBitVal) & mask;
          if (hitPullup && busWrEn)
            pullupQ <= busWrData & mask;
          else if (hitPullup && busBitWrEn)
            pullupQ <= setBit(pullupRd[k], busBitSel, busBitVal) & mask;
        end
      end

      // pin drivers follow the registers one cycle later
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pinOutQ[k] <= `BYTE_ZERO;
          pinOeQ[k] <= `BYTE_ZERO;
          pullupOutQ[k] <= `BYTE_ZERO;
        end
        else
        begin
          pinOutQ[k] <= ((latchQ & altAnd[k]) | altOr[k]) & mask;
          pinOeQ[k] <= ~dirQ & mask;
          // an alternate output is always in output mode, so the same gate covers it
          pullupOutQ[k] <= pullupQ & dirQ & mask;
        end
      end
    end
  endgenerate

  assign port0PinOut = pinOutQ[`SLOT_PORT0];
  assign port0PinOe = pinOeQ[`SLOT_PORT0];
  assign port0Pullup = pullupOutQ[`SLOT_PORT0];
  assign port1PinOut = pinOutQ[`SLOT_PORT1];
  assign port1PinOe = pinOeQ[`SLOT_PORT1];
  assign port1Pullup = pullupOutQ[`SLOT_PORT1];
  assign port5PinOut = pinOutQ[`SLOT_PORT5];
  assign port5PinOe = pinOeQ[`SLOT_PORT5];
  assign port5Pullup = pullupOutQ[`SLOT_PORT5];

  // input-only port: synchronised levels, both stages reset to zero
  reg [3:0] lvl2AQ;
  reg [3:0] lvl2BQ;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lvl2AQ <= 4'h0;
      lvl2BQ <= 4'h0;
    end
    else
    begin
      lvl2AQ <= port2PinIn;
      lvl2BQ <= lvl2AQ;
    end
  end

  // read multiplexer; unmapped addresses and writes to port 2 are ignored
  reg [7:0] rdMux;
  always @*
  begin
    case (busAddr)
      `PORT0_DATA_ADDR: rdMux = dataRd[`SLOT_PORT0];
      `PORT1_DATA_ADDR: rdMux = dataRd[`SLOT_PORT1];
      `PORT5_DATA_ADDR: rdMux = dataRd[`SLOT_PORT5];
      `PORT2_LEVEL_ADDR: rdMux = {4'h0, lvl2BQ} & `PORT2_MASK;
      `PORT0_DIR_ADDR: rdMux = dirRd[`SLOT_PORT0];
      `PORT1_DIR_ADDR: rdMux = dirRd[`SLOT_PORT1];
      `PORT5_DIR_ADDR: rdMux = dirRd[`SLOT_PORT5];
      `PORT0_PULLUP_ADDR: rdMux = pullupRd[`SLOT_PORT0];
      `PORT1_PULLUP_ADDR: rdMux = pullupRd[`SLOT_PORT1];
      `PORT5_PULLUP_ADDR: rdMux = pullupRd[`SLOT_PORT5];
      default: rdMux = `BYTE_ZERO;
    endcase
  end

  reg [7:0] rdDataQ;
  reg rdValidQ;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdDataQ <= `BYTE_ZERO;
      rdValidQ <= 1'b0;
    end
    else
    begin
      rdValidQ <= busRdEn;
      if (busRdEn)
        rdDataQ <= rdMux;
    end
  end
  assign busRdData = rdDataQ;
  assign busRdValid = rdValidQ;

  // alternate-function input taps, taken from the synchronised pin levels
  reg rxdQ;
  reg flashQ;
  reg timerAQ;
  reg timerB1Q;
  reg timerB2Q;
  reg [3:0] irqQ;
  reg irqFiveQ;
  reg convTrigQ;
  reg outStopQ;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rxdQ <= 1'b0;
      flashQ <= 1'b0;
      timerAQ <= 1'b0;
      timerB1Q <= 1'b0;
      timerB2Q <= 1'b0;
      irqQ <= 4'h0;
      irqFiveQ <= 1'b0;
      convTrigQ <= 1'b0;
      outStopQ <= 1'b0;
    end
    else
    begin
      rxdQ <= pinLevel[`SLOT_PORT1][`RXD_BIT];
      flashQ <= pinLevel[`SLOT_PORT1][`FLASH_MODE_BIT];
      timerAQ <= pinLevel[`SLOT_PORT5][`TIMER_A_BIT];
      timerB1Q <= pinLevel[`SLOT_PORT5][`TIMER_B_FIRST_BIT];
      timerB2Q <= pinLevel[`SLOT_PORT5][`TIMER_B_SECOND_BIT];
      irqQ <= pinLevel[`SLOT_PORT0][3:0];
      irqFiveQ <= pinLevel[`SLOT_PORT5][`IRQ_FIVE_BIT];
      convTrigQ <= pinLevel[`SLOT_PORT0][`CONV_TRIG_BIT];
      outStopQ <= pinLevel[`SLOT_PORT0][`OUT_STOP_BIT];
    end
  end
  assign serialReceiveIn = rxdQ;
  assign flashModeSelect = flashQ;
  assign timerAInput = timerAQ;
  assign timerBInputFirst = timerB1Q;
  assign timerBInputSecond = timerB2Q;
  assign extIrqLines = irqQ;
  assign extIrqLineFive = irqFiveQ;
  assign converterTriggerIn = convTrigQ;
  assign timerOutputStopIn = outStopQ;

endmodule

// ===== port_regs_sva.sv
// assertions on the bus answer and pin control outputs of the port register block
`timescale 1ns/100ps
`include "port_regs_defs.vh"
module port_regs_sva (
  input wire clk,
  input wire nrst,
  input wire busWrEn,
  input wire busBitWrEn,
  input wire busRdEn,
  input wire [7:0] busRdData,
  input wire busRdValid,
  input wire [7:0] port0PinOe,
  input wire [7:0] port0Pullup,
  input wire [7:0] port1PinOe,
  input wire [7:0] port1Pullup,
  input wire [7:0] port5PinOe,
  input wire [7:0] port5Pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  rd_answer_a: assert property (busRdEn |=> busRdValid)
    else $error("read strobe not answered");
  rd_pulse_a: assert property (busRdValid |-> $past(busRdEn))
    else $error("read valid without strobe");
  rd_hold_a: assert property (!busRdValid |-> $stable(busRdData))
    else $error("read data moved between reads");
  pull_zero_a: assert property ((port0Pullup & port0PinOe) == 8'h00)
    else $error("port0 pull-up on output pin");
  pull_one_a: assert property ((port1Pullup & port1PinOe) == 8'h00)
    else $error("port1 pull-up on output pin");
  pull_five_a: assert property ((port5Pullup & port5PinOe) == 8'h00)
    else $error("port5 pull-up on output pin");
  pin_mask_a: assert property ((((port0PinOe | port0Pullup) & ~`PORT0_MASK) |
    ((port1PinOe | port1Pullup) & ~`PORT1_MASK) |
    ((port5PinOe | port5Pullup) & ~`PORT5_MASK)) == 8'h00)
    else $error("control on unimplemented pin");
  oe_cause_a: assert property ($changed({port0PinOe, port1PinOe, port5PinOe})
    |-> $past(busWrEn || busBitWrEn, 2))
    else $error("output enable moved without a write");
  pu_cause_a: assert property ($changed({port0Pullup, port1Pullup, port5Pullup})
    |-> $past(busWrEn || busBitWrEn, 2))
    else $error("pull-up moved without a write");
endmodule

// ===== board_model.sv
// board-side model of one port: resolves each pin from device, board and pull-up
`timescale 1ns/100ps
module board_model (
  input wire clk,
  input wire [7:0] pinOut,
  input wire [7:0] pinOe,
  input wire [7:0] puEn,
  input wire [7:0] drive,
  input wire [7:0] driveEn,
  output wire [7:0] pinLevel
);
  reg [7:0] floatPat = 8'h55;
  // an open pin wanders, so nothing may lean on its last level
  always @(posedge clk)
    floatPat <= ~floatPat;
  assign pinLevel = (pinOe & pinOut) | (~pinOe & driveEn & drive)
    | (~pinOe & ~driveEn & (puEn | floatPat));
endmodule

// ===== test_port_regs.sv
// self-checking bench for the port register block
`timescale 1ns/100ps
`include "port_regs_defs.vh"
module test_port_regs;
  reg clk = 0;
  reg nrst = 0;
  reg [15:0] busAddr = 16'h0000;
  reg busWrEn = 0;
  reg [7:0] busWrData = 8'h00;
  reg busBitWrEn = 0;
  reg [2:0] busBitSel = 3'h0;
  reg busBitVal = 0;
  reg busRdEn = 0;
  reg [3:0] p2In = 4'hA;
  reg [2:0] perOut = 3'h7;
  reg [7:0] drv0 = 8'h05;
  reg [7:0] den0 = 8'hFF;
  wire [7:0] busRdData;
  wire busRdValid;
  wire [7:0] p0In, p0Out, p0Oe, p0Pu, p1In, p1Out, p1Oe, p1Pu, p5In, p5Out, p5Oe, p5Pu;
  // alternate-function input taps, packed as rx, flash, ta, tb1, tb2, irq5, trig, stop
  wire [7:0] taps;
  wire [3:0] tapIrq;
  integer failures = 0;
  integer checked = 0;
  initial
    forever #5 clk = ~clk;
  port_regs port_regs_i (.clk(clk), .nrst(nrst), .busAddr(busAddr), .busWrEn(busWrEn),
    .busWrData(busWrData), .busBitWrEn(busBitWrEn), .busBitSel(busBitSel),
    .busBitVal(busBitVal), .busRdEn(busRdEn), .busRdData(busRdData),
    .busRdValid(busRdValid), .port0PinIn(p0In), .port0PinOut(p0Out), .port0PinOe(p0Oe),
    .port0Pullup(p0Pu), .port1PinIn(p1In), .port1PinOut(p1Out), .port1PinOe(p1Oe),
    .port1Pullup(p1Pu), .port5PinIn(p5In), .port5PinOut(p5Out), .port5PinOe(p5Oe),
    .port5Pullup(p5Pu), .port2PinIn(p2In), .serialTransmitOut(perOut[0]),
    .timerAOutput(perOut[1]), .timerBOutput(perOut[2]), .serialReceiveIn(taps[7]),
    .flashModeSelect(taps[6]), .timerAInput(taps[5]), .timerBInputFirst(taps[4]),
    .timerBInputSecond(taps[3]), .extIrqLines(tapIrq), .extIrqLineFive(taps[2]),
    .converterTriggerIn(taps[1]), .timerOutputStopIn(taps[0]));
  board_model board_model_i (.clk(clk), .pinOut(p0Out), .pinOe(p0Oe), .puEn(p0Pu),
    .drive(drv0), .driveEn(den0), .pinLevel(p0In));
  board_model board_model_i1 (.clk(clk), .pinOut(p1Out), .pinOe(p1Oe), .puEn(p1Pu),
    .drive(8'hD0), .driveEn(8'hFF), .pinLevel(p1In));
  board_model board_model_i5 (.clk(clk), .pinOut(p5Out), .pinOe(p5Oe), .puEn(p5Pu),
    .drive(8'h11), .driveEn(8'hFF), .pinLevel(p5In));
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(negedge clk);
      busAddr = a;
      busWrData = d;
      busWrEn = 1;
      @(negedge clk);
      busWrEn = 0;
    end
  endtask
  task bw(input [15:0] a, input [2:0] s, input v);
    begin
      @(negedge clk);
      busAddr = a;
      busBitSel = s;
      busBitVal = v;
      busBitWrEn = 1;
      @(negedge clk);
      busBitWrEn = 0;
    end
  endtask
  // the answer stands for one cycle only, so it is looked at right after the strobe edge
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(negedge clk);
      busAddr = a;
      busRdEn = 1;
      @(negedge clk);
      busRdEn = 0;
      chk({7'h00, busRdValid}, 8'h01);
      chk(busRdData, e);
    end
  endtask
  initial
  begin
    #100000;
    failures = failures + 1;
    give_verdict;
  end
  initial
  begin
    repeat (6) @(negedge clk);
    nrst = 1;
    rd(`PORT0_DIR_ADDR, 8'hFF);
    rd(`PORT1_DIR_ADDR, 8'hFF);
    rd(`PORT5_DIR_ADDR, 8'hFF);
    rd(`PORT0_PULLUP_ADDR, 8'h00);
    rd(`PORT1_PULLUP_ADDR, 8'h00);
    rd(`PORT5_PULLUP_ADDR, 8'h00);
    rd(`PORT0_DATA_ADDR, 8'h05);
    rd(`PORT1_DATA_ADDR, 8'hD0);
    wr(`PORT2_LEVEL_ADDR, 8'h05);
    rd(`PORT2_LEVEL_ADDR, 8'h0A);
    rd(16'hFF10, 8'h00);
    chk(p0Oe | p1Oe | p5Oe | p0Pu | p1Pu | p5Pu, 8'h00);
    $display("reset test done");
    wr(`PORT5_DIR_ADDR, 8'hE6);
    rd(`PORT5_DATA_ADDR, 8'h00);
    chk(p5Out, 8'h11);
    perOut = 3'h1;
    repeat (2) @(negedge clk);
    chk(p5Out, 8'h00);
    drv0 = 8'h00;
    wr(`PORT0_DIR_ADDR, 8'hF5);
    rd(`PORT0_DIR_ADDR, 8'hF5);
    wr(`PORT0_DATA_ADDR, 8'h0F);
    rd(`PORT0_DATA_ADDR, 8'h0A);
    chk(p0Oe, 8'h0A);
    wr(`PORT0_DIR_ADDR, 8'h00);
    rd(`PORT0_DIR_ADDR, 8'hF0);
    rd(`PORT0_DATA_ADDR, 8'h0F);
    chk(p0Out, 8'h0F);
    $display("latch test done");
    wr(`PORT0_PULLUP_ADDR, 8'hFF);
    rd(`PORT0_PULLUP_ADDR, 8'h0F);
    chk(p0Pu, 8'h00);
    wr(`PORT0_DIR_ADDR, 8'hFF);
    den0 = 8'h00;
    repeat (4) @(negedge clk);
    chk(p0Pu, 8'h0F);
    rd(`PORT0_DATA_ADDR, 8'h0F);
    $display("pull-up test done");
    wr(`PORT1_DIR_ADDR, 8'hF7);
    bw(`PORT1_DATA_ADDR, 3'h3, 1'b1);
    wr(`PORT1_DIR_ADDR, 8'h00);
    rd(`PORT1_DATA_ADDR, 8'hD8);
    chk(p1Out, 8'hD8);
    bw(`PORT1_DIR_ADDR, 3'h7, 1'b1);
    rd(`PORT1_DIR_ADDR, 8'hA7);
    bw(`PORT5_PULLUP_ADDR, 3'h0, 1'b1);
    rd(`PORT5_PULLUP_ADDR, 8'h01);
    chk(p5Pu, 8'h00);
    chk(taps, 8'hC3);
    chk({4'h0, tapIrq}, 8'h0F);
    $display("bit write test done");
    nrst = 0;
    repeat (2) @(negedge clk);
    chk(p0Oe | p1Oe | p5Oe | p0Pu, 8'h00);
    nrst = 1;
    rd(`PORT1_DIR_ADDR, 8'hFF);
    rd(`PORT0_PULLUP_ADDR, 8'h00);
    $display("second reset test done");
    give_verdict;
  end
endmodule
bind port_regs port_regs_sva port_regs_sva_i (.clk(clk), .nrst(nrst), .busWrEn(busWrEn),
  .busBitWrEn(busBitWrEn), .busRdEn(busRdEn), .busRdData(busRdData),
  .busRdValid(busRdValid), .port0PinOe(port0PinOe), .port0Pullup(port0Pullup),
  .port1PinOe(port1PinOe), .port1Pullup(port1Pullup), .port5PinOe(port5PinOe),
  .port5Pullup(port5Pullup));
